// >>> pkg/pll_ctrl_pkg.sv
// Constants, types and register map of the PLL control block
package pll_ctrl_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [31:0] ADDR_PLL_CONTROL    = 32'h029a0100;
    localparam logic [31:0] ADDR_PLL_MULTIPLIER = 32'h029a0110;

    // ****************************************
    // Control register fields
    // ****************************************
    localparam int          CTL_MODE_BIT     = 0;
    localparam int          CTL_PWRDN_BIT    = 1;
    localparam int          CTL_RESET_BIT    = 3;
    localparam logic [31:0] CTL_WRITE_MASK   = 32'h0000000b;
    localparam logic [31:0] CTL_READ_ONES    = 32'h00000040;
    localparam logic [31:0] CTL_RESET_VALUE  = 32'h00000008;

    // ****************************************
    // Multiplier register fields
    // ****************************************
    localparam int          MULT_W           = 5;
    localparam logic [31:0] MULT_WRITE_MASK  = 32'h0000001f;
    localparam logic [4:0]  MULT_RESET_VALUE = 5'h00;

    // ****************************************
    // Pre-divider ratio codes
    // ****************************************
    localparam int         RATIO_W    = 5;
    localparam logic [4:0] RATIO_DIV1 = 5'h00;
    localparam logic [4:0] RATIO_DIV2 = 5'h01;
    localparam logic [4:0] RATIO_DIV3 = 5'h02;

    typedef enum logic [1:0] {
        SRC_CPU      = 2'b00,
        SRC_EMULATOR = 2'b01,
        SRC_DMA      = 2'b10,
        SRC_HOST     = 2'b11
    } master_e;

    typedef struct packed {
        logic        valid;
        logic        write;
        master_e     source;
        logic [31:0] addr;
        logic [31:0] wdata;
    } reg_req_s;

    typedef struct packed {
        logic        ack;
        logic        denied;
        logic        unmapped;
        logic [31:0] rdata;
    } reg_rsp_s;

    typedef struct packed {
        logic       pll_reset;
        logic       pll_power_down;
        logic       pll_mode;
        logic       reference_pre_divider_in_path;
        logic       pll_output_enable;
        logic       refclk_bypass;
        logic [5:0] multiplier;
        logic [1:0] pre_divide;
        logic       ratio_reserved;
    } pll_drive_s;

endpackage : pll_ctrl_pkg

// >>> hw/pll_control_and_multiplier_regs.sv
// PLL control and multiplier registers with derived clock-path controls
//
// How it works
// - Only the processor core or the debug emulator may read or write these registers.
// - Control bits 31:8 and 2 and multiplier bits 31:5 read zero and ignore writes.
// - Control bit 6 always reads one whatever is written.
// - Control bit 3 holds the PLL in reset while set and releases it when clear.
// - Control bit 1 powers the PLL analog circuitry down while set.
// - With the mode bit clear the pre-divider and PLL are bypassed and clocks use the reference.
// - With the mode bit set the pre-divider and PLL are in path and the PLL output is enabled.
// - The 5-bit multiplier code gives a multiplication of code plus one.
// - Output frequency is set by the multiplier together with the pre-divide ratio.
// - Ratio codes 0, 1 and 2 divide by 1, 2 and 3; other codes are reserved.
`timescale 1ns/1ps

module pll_control_and_multiplier_regs
    import pll_ctrl_pkg::*;
(
    input  wire logic               clock,
    input  wire logic               rst,
    input  wire reg_req_s           req,
    input  wire logic [RATIO_W-1:0] pre_divider_ratio,
    output reg_rsp_s                rsp,
    output pll_drive_s              drive
);

    // ****************************************
    // Decode
    // ****************************************
    logic [31:0]       ctl_store;
    logic [MULT_W-1:0] mult_code;
    logic [31:0]       next_ctl_store;
    logic [MULT_W-1:0] next_mult_code;
    pll_drive_s        next_drive;
    reg_rsp_s          next_rsp;

    wire trusted  = (req.source == SRC_CPU) || (req.source == SRC_EMULATOR);
    wire hit_ctl  = (req.addr == ADDR_PLL_CONTROL);
    wire hit_mult = (req.addr == ADDR_PLL_MULTIPLIER);
    wire mapped   = hit_ctl || hit_mult;
    wire accepted = req.valid && trusted;
    wire wr_ctl   = accepted && req.write && hit_ctl;
    wire wr_mult  = accepted && req.write && hit_mult;
    wire rd_accepted = accepted && !req.write;

    // Stored bits only; reserved ones are masked off on the way in
    assign next_ctl_store = wr_ctl ? (req.wdata & CTL_WRITE_MASK) : ctl_store;
    assign next_mult_code = wr_mult ? req.wdata[MULT_W-1:0] : mult_code;

    // ****************************************
    // Read data
    // ****************************************
    wire [31:0] ctl_view  = (ctl_store & CTL_WRITE_MASK) | CTL_READ_ONES;
    wire [31:0] mult_view = {{(32 - MULT_W){1'b0}}, mult_code} & MULT_WRITE_MASK;
    wire [31:0] read_sel  = hit_ctl  ? ctl_view  :
                            hit_mult ? mult_view : 32'h00000000;

    // Untrusted requests are still answered, flagged as denied
    always_comb begin
        next_rsp          = '0;
        next_rsp.ack      = req.valid;
        next_rsp.denied   = req.valid && !trusted;
        next_rsp.unmapped = accepted && !mapped;
        next_rsp.rdata    = rd_accepted ? read_sel : 32'h00000000;
    end

    // ****************************************
    // Clock path controls
    // ****************************************
    wire mode_pll = next_ctl_store[CTL_MODE_BIT];

    // Reserved ratio codes are flagged and fall back to divide by one
    wire [1:0] divide_sel = (pre_divider_ratio == RATIO_DIV2) ? 2'h2 :
                            (pre_divider_ratio == RATIO_DIV3) ? 2'h3 : 2'h1;
    wire ratio_bad = (pre_divider_ratio != RATIO_DIV1) &&
                     (pre_divider_ratio != RATIO_DIV2) &&
                     (pre_divider_ratio != RATIO_DIV3);

    always_comb begin
        next_drive                   = '0;
        next_drive.pll_reset         = next_ctl_store[CTL_RESET_BIT];
        next_drive.pll_power_down    = next_ctl_store[CTL_PWRDN_BIT];
        next_drive.pll_mode          = mode_pll;
        next_drive.refclk_bypass     = !mode_pll;
        next_drive.reference_pre_divider_in_path    = mode_pll;
        next_drive.pll_output_enable = mode_pll;
        next_drive.multiplier        = {1'b0, next_mult_code} + 6'h01;
        next_drive.pre_divide        = divide_sel;
        next_drive.ratio_reserved    = ratio_bad;
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clock) begin
        if (rst) begin
            ctl_store <= CTL_RESET_VALUE;
            mult_code <= MULT_RESET_VALUE;
        end else begin
            ctl_store <= next_ctl_store;
            mult_code <= next_mult_code;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rsp <= '0;
        end else begin
            rsp <= next_rsp;
        end
    end

    // Outputs follow the register update on the same edge
    always_ff @(posedge clock) begin
        if (rst) begin
            drive                   <= '0;
            drive.pll_reset         <= CTL_RESET_VALUE[CTL_RESET_BIT];
            drive.refclk_bypass     <= 1'b1;
            drive.multiplier        <= 6'h01;
            drive.pre_divide        <= 2'h1;
        end else begin
            drive <= next_drive;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence foreign_write_s;
        req.valid && req.write && !trusted;
    endsequence

    sequence ctl_read_s;
        req.valid && !req.write && trusted && hit_ctl;
    endsequence

    sequence mult_read_s;
        req.valid && !req.write && trusted && hit_mult;
    endsequence

    sequence ctl_write_s;
        req.valid && req.write && trusted && hit_ctl;
    endsequence

    sequence mult_write_s;
        req.valid && req.write && trusted && hit_mult;
    endsequence

    chk_foreign_blocked: assert property (
        foreign_write_s |=> rsp.ack && rsp.denied && $stable(ctl_store) && $stable(mult_code))
        else $error("Foreign master changed a register");

    chk_ctl_zero_bits: assert property (
        ctl_read_s |=> rsp.rdata[31:8] == 24'h000000 && !rsp.rdata[2] &&
                       rsp.rdata[5:4] == 2'h0 && !rsp.rdata[7])
        else $error("Control reserved bits not zero");

    chk_mult_zero_bits: assert property (
        mult_read_s |=> rsp.rdata[31:5] == 27'h0000000)
        else $error("Multiplier reserved bits not zero");

    chk_bit6_one: assert property (
        ctl_read_s |=> rsp.rdata[6])
        else $error("Control bit 6 not read as one");

    chk_reset_bit: assert property (
        ctl_write_s |=> drive.pll_reset == $past(req.wdata[CTL_RESET_BIT])
                        ##1 (drive.pll_reset == ctl_store[CTL_RESET_BIT]))
        else $error("PLL reset does not follow control bit");

    chk_power_down: assert property (
        ctl_write_s |=> drive.pll_power_down == $past(req.wdata[CTL_PWRDN_BIT]))
        else $error("Power-down does not follow control bit");

    chk_bypass_path: assert property (
        (ctl_write_s and !req.wdata[CTL_MODE_BIT]) |=>
            drive.refclk_bypass && !drive.reference_pre_divider_in_path && !drive.pll_output_enable)
        else $error("Bypass mode path wrong");

    chk_pll_path: assert property (
        (ctl_write_s and req.wdata[CTL_MODE_BIT]) |=>
            !drive.refclk_bypass && drive.reference_pre_divider_in_path && drive.pll_output_enable)
        else $error("PLL mode path wrong");

    chk_mult_value: assert property (
        mult_write_s |=> drive.multiplier == {1'b0, $past(req.wdata[4:0])} + 6'h01)
        else $error("Multiplier is not code plus one");

    chk_ratio_divide: assert property (
        pre_divider_ratio == RATIO_DIV3 |=> drive.pre_divide == 2'h3 && !drive.ratio_reserved)
        else $error("Pre-divide ratio wrong");

    chk_ratio_flag: assert property (
        pre_divider_ratio > RATIO_DIV3 |=> drive.ratio_reserved && drive.pre_divide == 2'h1)
        else $error("Reserved ratio not flagged");

    chk_mult_readback: assert property (
        mult_write_s ##1 mult_read_s |=> rsp.rdata[4:0] == $past(req.wdata[4:0], 2))
        else $error("Multiplier read back wrong");

    chk_ctl_readback: assert property (
        ctl_write_s ##1 ctl_read_s |=>
            rsp.rdata[3:0] == ($past(req.wdata[3:0], 2) & 4'hb))
        else $error("Control read back wrong");

    // ****************************************
    // Access checks
    // ****************************************
    sequence foreign_read_s;
        req.valid && !req.write && !trusted;
    endsequence

    sequence unmapped_access_s;
        req.valid && trusted && !mapped;
    endsequence

    sequence any_write_s;
        req.valid && req.write;
    endsequence

    chk_ack_follows: assert property (
        req.valid |=> rsp.ack)
        else $error("Request not answered");

    chk_no_stray_ack: assert property (
        !req.valid |=> !rsp.ack && !rsp.denied && !rsp.unmapped)
        else $error("Answer without a request");

    chk_foreign_read: assert property (
        foreign_read_s |=> rsp.ack && rsp.denied && rsp.rdata == 32'h00000000)
        else $error("Foreign master read a register");

    chk_foreign_flags: assert property (
        req.valid && !trusted |=> !rsp.unmapped)
        else $error("Foreign access flagged unmapped");

    chk_emulator_write: assert property (
        req.valid && req.write && req.source == SRC_EMULATOR && hit_ctl |=>
            ctl_store == ($past(req.wdata) & CTL_WRITE_MASK))
        else $error("Emulator write not stored");

    // Unmapped accesses are answered so a stray access never hangs the bus
    chk_unmapped_kept: assert property (
        unmapped_access_s |=> rsp.unmapped && !rsp.denied && rsp.rdata == 32'h00000000 &&
                              $stable(ctl_store) && $stable(mult_code))
        else $error("Unmapped access not refused");

    chk_write_no_data: assert property (
        any_write_s |=> rsp.rdata == 32'h00000000)
        else $error("Write returned read data");

    chk_ctl_reserved: assert property (
        (ctl_store & ~CTL_WRITE_MASK) == 32'h00000000)
        else $error("Reserved control bit stored");

    chk_ctl_kept: assert property (
        !wr_ctl |=> $stable(ctl_store))
        else $error("Control changed without a write");

    chk_mult_kept: assert property (
        !wr_mult |=> $stable(mult_code))
        else $error("Multiplier changed without a write");

    chk_reset_values: assert property (
        $fell(rst) |-> ctl_store == CTL_RESET_VALUE && mult_code == MULT_RESET_VALUE &&
                       drive.pll_reset && drive.refclk_bypass && drive.multiplier == 6'h01)
        else $error("Reset values wrong");

    // ****************************************
    // Clock path checks
    // ****************************************
    // Drive fields mirror the state that the same edge stored
    chk_mode_bit: assert property (
        ctl_write_s |=> drive.pll_mode == $past(req.wdata[CTL_MODE_BIT]))
        else $error("Mode does not follow control bit");

    chk_path_mirror: assert property (
        drive.reference_pre_divider_in_path == drive.pll_mode && drive.pll_output_enable == drive.pll_mode &&
        drive.refclk_bypass == !drive.pll_mode)
        else $error("Clock path controls disagree");

    chk_mult_range: assert property (
        drive.multiplier != 6'h00 && drive.multiplier <= 6'h20)
        else $error("Multiplier out of range");

    // The ratio input must never disturb the multiplier path
    chk_mult_joint: assert property (
        !wr_mult |=> $stable(drive.multiplier))
        else $error("Multiplier moved without a write");

    chk_ratio_div1: assert property (
        pre_divider_ratio == RATIO_DIV1 |=> drive.pre_divide == 2'h1 && !drive.ratio_reserved)
        else $error("Ratio code 0 not divide by one");

    chk_ratio_div2: assert property (
        pre_divider_ratio == RATIO_DIV2 |=> drive.pre_divide == 2'h2 && !drive.ratio_reserved)
        else $error("Ratio code 1 not divide by two");

endmodule : pll_control_and_multiplier_regs

// >>> sim/pll_control_and_multiplier_regs_tb.sv
// Self-checking testbench for the PLL control and multiplier registers
`timescale 1ns/1ps

module pll_control_and_multiplier_regs_tb
    import pll_ctrl_pkg::*;
;
    logic               clock;
    logic               rst;
    reg_req_s           req;
    logic [RATIO_W-1:0] pre_divider_ratio;
    reg_rsp_s           rsp;
    pll_drive_s         drive;
    int                 failures;
    int                 check_count;

    // Waits in bench clocks; assumes the reference is not slower than this clock
    localparam int RESET_HOLD = 128;
    localparam int LOCK_WAIT  = 2000;

    pll_control_and_multiplier_regs dut (
        .clock             (clock),
        .rst               (rst),
        .req               (req),
        .pre_divider_ratio (pre_divider_ratio),
        .rsp               (rsp),
        .drive             (drive)
    );

    // ****************
    // Helpers
    // ****************
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // One request, then sample the registered answer just after the taking edge
    task automatic access(input logic wr, input master_e src, input logic [31:0] addr,
                          input logic [31:0] wdata);
        @(posedge clock);
        req <= '{valid: 1'b1, write: wr, source: src, addr: addr, wdata: wdata};
        @(posedge clock);
        req.valid <= 1'b0;
        #1;
        check("ack", rsp.ack, 1'b1);
    endtask : access

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : print_verdict

    // ****************
    // Tests
    // ****************
    task automatic test_reset();
        check("rst pll_reset", drive.pll_reset, 1'b1);
        check("rst bypass", drive.refclk_bypass, 1'b1);
        check("rst mult", drive.multiplier, 6'h01);
        access(1'b0, SRC_CPU, ADDR_PLL_CONTROL, 32'h0);
        check("rst ctl read", rsp.rdata, 32'h00000048);
        access(1'b0, SRC_EMULATOR, ADDR_PLL_MULTIPLIER, 32'h0);
        check("rst mult read", rsp.rdata, 32'h00000000);
        $display("test reset done");
    endtask : test_reset

    task automatic test_control();
        // Reserved bits 7 and 5:4 kept zero, all others set
        access(1'b1, SRC_CPU, ADDR_PLL_CONTROL, 32'hffffff4f);
        check("wr rdata", rsp.rdata, 32'h0);
        check("pll_reset", drive.pll_reset, 1'b1);
        check("power_down", drive.pll_power_down, 1'b1);
        check("mode", drive.pll_mode, 1'b1);
        check("reference_pre_divider path", drive.reference_pre_divider_in_path, 1'b1);
        check("out enable", drive.pll_output_enable, 1'b1);
        check("bypass", drive.refclk_bypass, 1'b0);
        access(1'b0, SRC_CPU, ADDR_PLL_CONTROL, 32'h0);
        check("ctl read", rsp.rdata, 32'h0000004b);
        repeat (RESET_HOLD) @(posedge clock);
        access(1'b1, SRC_CPU, ADDR_PLL_CONTROL, 32'h0);
        check("pll_reset off", drive.pll_reset, 1'b0);
        check("power up", drive.pll_power_down, 1'b0);
        check("bypass on", drive.refclk_bypass, 1'b1);
        check("reference_pre_divider out", drive.reference_pre_divider_in_path, 1'b0);
        access(1'b0, SRC_CPU, ADDR_PLL_CONTROL, 32'h0);
        check("ctl bit6", rsp.rdata, 32'h00000040);
        repeat (LOCK_WAIT) @(posedge clock);
        access(1'b1, SRC_CPU, ADDR_PLL_CONTROL, 32'h00000001);
        check("pll mode", drive.pll_mode, 1'b1);
        check("pll bypass off", drive.refclk_bypass, 1'b0);
        check("pll out on", drive.pll_output_enable, 1'b1);
        access(1'b1, SRC_EMULATOR, ADDR_PLL_CONTROL, 32'h00000008);
        check("emu write", drive.pll_reset, 1'b1);
        check("emu bypass", drive.pll_mode, 1'b0);
        $display("test control done");
    endtask : test_control

    task automatic test_multiplier();
        logic [4:0] codes [6] = '{5'h00, 5'h0e, 5'h13, 5'h18, 5'h1d, 5'h1f};
        foreach (codes[i]) begin
            access(1'b1, SRC_CPU, ADDR_PLL_MULTIPLIER, {27'h7ffffff, codes[i]});
            check("multiplier", drive.multiplier, {1'b0, codes[i]} + 6'h01);
            access(1'b0, SRC_CPU, ADDR_PLL_MULTIPLIER, 32'h0);
            check("mult read", rsp.rdata, {27'h0, codes[i]});
        end
        $display("test multiplier done");
    endtask : test_multiplier

    task automatic test_refused();
        master_e others [2] = '{SRC_DMA, SRC_HOST};
        access(1'b1, SRC_CPU, ADDR_PLL_MULTIPLIER, 32'h00000013);
        foreach (others[i]) begin
            access(1'b1, others[i], ADDR_PLL_MULTIPLIER, 32'h00000005);
            check("denied wr", rsp.denied, 1'b1);
            access(1'b0, others[i], ADDR_PLL_CONTROL, 32'h0);
            check("denied rd", rsp.rdata, 32'h0);
        end
        // Software may not write unmapped space, so only a read probes it
        access(1'b0, SRC_CPU, 32'h029a0104, 32'h0);
        check("unmapped", rsp.unmapped, 1'b1);
        check("unmapped den", rsp.denied, 1'b0);
        check("unmapped rd", rsp.rdata, 32'h0);
        access(1'b0, SRC_CPU, ADDR_PLL_MULTIPLIER, 32'h0);
        check("mult kept", rsp.rdata, 32'h00000013);
        check("mult x20", drive.multiplier, 6'h14);
        $display("test refused done");
    endtask : test_refused

    task automatic test_ratio();
        for (int i = 0; i < 4; i++) begin
            @(posedge clock);
            pre_divider_ratio <= 5'(i);
            @(posedge clock);
            #1;
            check("pre_divide", drive.pre_divide, (i < 3) ? 2'(i + 1) : 2'h1);
            check("ratio rsvd", drive.ratio_reserved, (i > 2));
            check("mult joint", drive.multiplier, 6'h14);
        end
        $display("test ratio done");
    endtask : test_ratio

    // Write then read on consecutive edges; the read must see the new value
    task automatic test_back_to_back();
        @(posedge clock);
        req <= '{valid: 1'b1, write: 1'b1, source: SRC_CPU, addr: ADDR_PLL_MULTIPLIER,
                 wdata: 32'h00000018};
        @(posedge clock);
        req <= '{valid: 1'b1, write: 1'b0, source: SRC_EMULATOR, addr: ADDR_PLL_MULTIPLIER,
                 wdata: 32'h00000000};
        @(posedge clock);
        req.valid <= 1'b0;
        #1;
        check("b2b mult ack", rsp.ack, 1'b1);
        check("b2b mult", rsp.rdata, 32'h00000018);
        check("b2b x25", drive.multiplier, 6'h19);
        @(posedge clock);
        req <= '{valid: 1'b1, write: 1'b1, source: SRC_CPU, addr: ADDR_PLL_CONTROL,
                 wdata: 32'h0000000a};
        @(posedge clock);
        req <= '{valid: 1'b1, write: 1'b0, source: SRC_CPU, addr: ADDR_PLL_CONTROL,
                 wdata: 32'h00000000};
        @(posedge clock);
        req.valid <= 1'b0;
        #1;
        check("b2b ctl", rsp.rdata, 32'h0000004a);
        check("b2b power", drive.pll_power_down, 1'b1);
        check("b2b reset", drive.pll_reset, 1'b1);
        $display("test back to back done");
    endtask : test_back_to_back

    // Generous bound: the whole sequence needs about 2200 cycles
    initial begin
        #(25 * 10000);
        failures++;
        print_verdict();
    end

    initial begin
        failures          = 0;
        check_count       = 0;
        rst               = 1'b1;
        req               = '0;
        pre_divider_ratio = 5'h00;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        #1;
        test_reset();
        test_control();
        test_multiplier();
        test_refused();
        test_ratio();
        test_back_to_back();
        print_verdict();
    end
endmodule : pll_control_and_multiplier_regs_tb
